// ==== verilog/serial_mp_pkg.sv ====
// constants, register map and carrier types of the multiprocessor serial port
package serial_mp_pkg;

  // ==========================================================================
  // register byte offsets
  localparam logic [7:0] OFS_FRAME  = 8'h00;
  localparam logic [7:0] OFS_LINE   = 8'h04;
  localparam logic [7:0] OFS_BAUD   = 8'h08;
  localparam logic [7:0] OFS_TXCTL  = 8'h0C;
  localparam logic [7:0] OFS_RXSTAT = 8'h10;
  localparam logic [7:0] OFS_RX_HOLDING_BUFFER  = 8'h14;
  localparam logic [7:0] OFS_TX_HOLDING_BUFFER  = 8'h18;
  localparam logic [7:0] OFS_PINCTL = 8'h1C;

  // ==========================================================================
  // field positions
  localparam int LINE_RX_EN   = 0;
  localparam int LINE_TX_EN   = 1;
  localparam int LINE_DORMANT = 2;
  localparam int LINE_MARK    = 3;
  localparam int LINE_INT_CLK = 4;
  localparam int TXC_IRQ_EN   = 0;
  localparam int TXC_SHF_IDLE = 6;
  localparam int TXC_EMPTY    = 7;
  localparam int RXS_IRQ_EN   = 0;
  localparam int RXS_ADDR     = 1;
  localparam int RXS_PERR     = 2;
  localparam int RXS_OVR      = 3;
  localparam int RXS_FERR     = 4;
  localparam int RXS_BRK      = 5;
  localparam int RXS_FULL     = 6;
  localparam int PIN_ROLE     = 1;
  localparam int PIN_LEVEL    = 3;

  // ==========================================================================
  // reset values and timing counts
  localparam logic [7:0]  FRAME_RESET     = 8'h00;
  localparam logic [15:0] BAUD_RESET      = 16'h0000;
  localparam logic [3:0]  START_LOW_LAST  = 4'h7;
  localparam logic [3:0]  START_SKIP_TO   = 4'h8;
  localparam logic [3:0]  VOTE_FIRST      = 4'h6;
  localparam logic [3:0]  VOTE_SECOND     = 4'h7;
  localparam logic [3:0]  VOTE_DECIDE     = 4'h8;
  localparam logic [3:0]  SUB_LAST        = 4'hF;
  localparam logic [3:0]  IDLE_BLOCK_BITS = 4'hA;
  localparam logic [3:0]  BREAK_BITS      = 4'hA;
  localparam logic [3:0]  MARK_IDLE_BITS  = 4'hB;

  // ==========================================================================
  // types
  typedef enum logic {TX_IDLE, TX_SHIFT} tx_state_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS, RX_BREAK} rx_state_t;

  typedef struct packed {
    logic       two_stop;
    logic       even_parity;
    logic       parity_en;
    logic       timing_mode_select;
    logic       wake_method_select;
    logic [2:0] char_len;
  } frame_format_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_t;

  typedef struct packed {
    logic [12:0] bits;
    logic [3:0]  nbits;
  } tx_frame_t;

endpackage : serial_mp_pkg

// ==== verilog/serial_multiproc_wake_modes.sv ====
// multiprocessor serial port: wake-up modes, async and isosync timing, APB registers
`timescale 1ns/1ps

module serial_multiproc_wake_modes (
  input  wire logic                    mclk,
  input  wire logic                    rst,
  input  wire serial_mp_pkg::apb_req_t apb_req,
  output serial_mp_pkg::apb_rsp_t      apb_rsp,
  input  wire logic                    serial_in_pin,
  output logic                         serial_out_pin,
  input  wire logic                    serial_bit_clock_in,
  output logic                         serial_bit_clock_out,
  output logic                         serial_bit_clock_oe_n,
  output logic                         rx_irq,
  output logic                         tx_irq
);

  // ==========================================================================
  // state
  typedef struct packed {
    logic                        rxd_s1;
    logic                        rxd_s2;
    logic                        sck_s1;
    logic                        sck_s2;
    logic                        sck_s3;
    logic [15:0]                 div;
    logic                        sclk;
    logic                        clk_oe_n;
    serial_mp_pkg::frame_format_t fmt;
    logic [15:0]                 baud;
    logic                        rx_enable;
    logic                        tx_enable;
    logic                        receive_dormant;
    logic                        tx_block_mark;
    logic                        clk_internal;
    logic                        clock_pin_role;
    logic                        tx_irq_en;
    logic                        rx_irq_en;
    logic [7:0]                  tx_holding_buffer;
    logic                        tx_empty_flag;
    serial_mp_pkg::tx_state_t    tx_state;
    logic [12:0]                 tx_shifter;
    logic [3:0]                  tx_left;
    logic [3:0]                  tx_sub;
    logic                        tx_mark_latch;
    logic                        serial_out;
    serial_mp_pkg::rx_state_t    rx_state;
    logic [11:0]                 rx_shifter;
    logic [3:0]                  rx_idx;
    logic [3:0]                  rx_nbits;
    logic [3:0]                  rx_sub;
    logic [1:0]                  rx_vote;
    logic                        rx_armed;
    logic                        rx_is_addr;
    logic [3:0]                  idle_cnt;
    logic                        idle_seen;
    logic [3:0]                  brk_cnt;
    logic [7:0]                  rx_holding_buffer;
    logic                        rx_full_flag;
    logic                        rx_address_flag;
    logic                        err_parity;
    logic                        err_overrun;
    logic                        err_framing;
    logic                        break_seen_flag;
    serial_mp_pkg::apb_rsp_t     rsp;
    logic                        rx_irq;
    logic                        tx_irq;
  } state_t;

  state_t s;
  state_t next_s;

  // ==========================================================================
  // functions
  function automatic logic [7:0] data_mask(input logic [7:0] d, input logic [2:0] len_m1);
    data_mask = d & (8'hFF >> (3'h7 - len_m1));
  endfunction : data_mask

  function automatic logic reg_mapped(input logic [7:0] a);
    reg_mapped = (a[1:0] == 2'h0) && (a <= serial_mp_pkg::OFS_PINCTL);
  endfunction : reg_mapped

  function automatic serial_mp_pkg::tx_frame_t build_frame(input logic [7:0] data,
                                                           input serial_mp_pkg::frame_format_t f,
                                                           input logic mark);
    serial_mp_pkg::tx_frame_t r;
    logic [7:0] d;
    int pos;
    r.bits  = '1;
    r.nbits = serial_mp_pkg::MARK_IDLE_BITS;
    d       = data_mask(data, f.char_len);
    pos     = 1;
    // marked idle-mode frame: the dummy word is swallowed by eleven idle bits
    if (f.wake_method_select || !mark) begin
      r.bits[0] = 1'b0;
      for (int i = 0; i < 8; i++) begin
        if (i <= int'(f.char_len)) begin
          r.bits[pos] = d[i];
          pos++;
        end
      end
      if (f.parity_en) begin
        r.bits[pos] = f.even_parity ? ^d : ~^d;
        pos++;
      end
      if (f.wake_method_select) begin
        r.bits[pos] = mark;
        pos++;
      end
      pos = pos + (f.two_stop ? 2 : 1);
      r.nbits = 4'(pos);
    end
    return r;
  endfunction : build_frame

  function automatic logic [31:0] read_word(input state_t st, input logic [7:0] a);
    read_word = 32'h0000_0000;
    unique case (a)
      serial_mp_pkg::OFS_FRAME:  read_word[7:0] = st.fmt;
      serial_mp_pkg::OFS_BAUD:   read_word[15:0] = st.baud;
      serial_mp_pkg::OFS_RX_HOLDING_BUFFER:  read_word[7:0] = st.rx_holding_buffer;
      serial_mp_pkg::OFS_TX_HOLDING_BUFFER:  read_word[7:0] = st.tx_holding_buffer;
      serial_mp_pkg::OFS_LINE: begin
        read_word[serial_mp_pkg::LINE_RX_EN]   = st.rx_enable;
        read_word[serial_mp_pkg::LINE_TX_EN]   = st.tx_enable;
        read_word[serial_mp_pkg::LINE_DORMANT] = st.receive_dormant;
        read_word[serial_mp_pkg::LINE_MARK]    = st.tx_block_mark;
        read_word[serial_mp_pkg::LINE_INT_CLK] = st.clk_internal;
      end
      serial_mp_pkg::OFS_TXCTL: begin
        read_word[serial_mp_pkg::TXC_IRQ_EN]   = st.tx_irq_en;
        read_word[serial_mp_pkg::TXC_SHF_IDLE] = (st.tx_state == serial_mp_pkg::TX_IDLE);
        read_word[serial_mp_pkg::TXC_EMPTY]    = st.tx_empty_flag;
      end
      serial_mp_pkg::OFS_RXSTAT: begin
        read_word[serial_mp_pkg::RXS_IRQ_EN] = st.rx_irq_en;
        read_word[serial_mp_pkg::RXS_ADDR]   = st.rx_address_flag;
        read_word[serial_mp_pkg::RXS_PERR]   = st.err_parity;
        read_word[serial_mp_pkg::RXS_OVR]    = st.err_overrun;
        read_word[serial_mp_pkg::RXS_FERR]   = st.err_framing;
        read_word[serial_mp_pkg::RXS_BRK]    = st.break_seen_flag;
        read_word[serial_mp_pkg::RXS_FULL]   = st.rx_full_flag;
      end
      serial_mp_pkg::OFS_PINCTL: begin
        read_word[serial_mp_pkg::PIN_ROLE]  = st.clock_pin_role;
        read_word[serial_mp_pkg::PIN_LEVEL] = st.sck_s2;
      end
      default: read_word = 32'h0000_0000;
    endcase
  endfunction : read_word

  // ==========================================================================
  // serial clock edges and frame decode helpers
  logic                     int_tick;
  logic                     rise;
  logic                     fall;
  logic                     async_m;
  logic                     tx_edge;
  logic                     setup;
  logic                     access;
  logic                     rxd;
  logic                     vote_bit;
  logic [7:0]               rx_data;
  logic [3:0]               par_idx;
  logic [3:0]               addr_idx;
  logic                     rx_par_bad;
  logic                     frame_addr;
  serial_mp_pkg::tx_frame_t tx_frame;
  localparam logic [3:0]    IDLE_LIMIT = serial_mp_pkg::IDLE_BLOCK_BITS;

  assign int_tick   = (s.div >= s.baud);
  assign rise       = s.clk_internal ? (int_tick && !s.sclk) : (s.sck_s2 && !s.sck_s3);
  assign fall       = s.clk_internal ? (int_tick && s.sclk) : (!s.sck_s2 && s.sck_s3);
  assign async_m    = s.fmt.timing_mode_select;
  assign tx_edge    = async_m ? (rise && s.tx_sub == serial_mp_pkg::SUB_LAST) : fall;
  assign setup      = apb_req.psel && !apb_req.penable;
  assign access     = apb_req.psel && apb_req.penable && s.rsp.pready;
  assign rxd        = s.rxd_s2;
  assign vote_bit   = (s.rx_vote == 2'h2) || ((s.rx_vote == 2'h1) && rxd);
  assign rx_data    = data_mask(s.rx_shifter[7:0], s.fmt.char_len);
  assign par_idx    = {1'b0, s.fmt.char_len} + 4'h1;
  assign addr_idx   = par_idx + {3'h0, s.fmt.parity_en};
  assign rx_par_bad = s.fmt.parity_en &&
                      (s.rx_shifter[par_idx] != (s.fmt.even_parity ? ^rx_data : ~^rx_data));
  assign frame_addr = s.fmt.wake_method_select ? s.rx_shifter[addr_idx] : s.rx_is_addr;
  assign tx_frame   = build_frame(s.tx_holding_buffer, s.fmt, s.tx_block_mark);

  // ==========================================================================
  // next state
  always_comb begin
    next_s = s;
    next_s.rxd_s1 = serial_in_pin;
    next_s.rxd_s2 = s.rxd_s1;
    next_s.sck_s1 = serial_bit_clock_in;
    next_s.sck_s2 = s.sck_s1;
    next_s.sck_s3 = s.sck_s2;

    // internal divider: one half period of the serial clock per wrap
    next_s.div = int_tick ? 16'h0000 : s.div + 16'h0001;
    if (int_tick) begin
      next_s.sclk = !s.sclk;
    end
    next_s.clk_oe_n = !(s.clk_internal && s.clock_pin_role);
    if (rise) begin
      next_s.tx_sub = s.tx_sub + 4'h1;
    end

    // software clears first so that a same-cycle hardware set wins
    if (access && !apb_req.pwrite && apb_req.paddr == serial_mp_pkg::OFS_RX_HOLDING_BUFFER) begin
      next_s.rx_full_flag = 1'b0;
    end
    if (access && apb_req.pwrite && apb_req.paddr == serial_mp_pkg::OFS_RXSTAT) begin
      next_s.err_parity      = s.err_parity && !apb_req.pwdata[serial_mp_pkg::RXS_PERR];
      next_s.err_overrun     = s.err_overrun && !apb_req.pwdata[serial_mp_pkg::RXS_OVR];
      next_s.err_framing     = s.err_framing && !apb_req.pwdata[serial_mp_pkg::RXS_FERR];
      next_s.break_seen_flag = s.break_seen_flag && !apb_req.pwdata[serial_mp_pkg::RXS_BRK];
    end

    // ==========================================================================
    // receiver
    if (rise) begin
      unique case (s.rx_state)
        serial_mp_pkg::RX_IDLE: begin
          if (!rxd) begin
            // a low ends the idle stretch even if it proves to be a glitch
            next_s.rx_is_addr = s.idle_seen && !s.fmt.wake_method_select;
            next_s.idle_seen  = 1'b0;
            next_s.idle_cnt   = 4'h0;
            next_s.rx_idx     = 4'h0;
            next_s.rx_vote    = 2'h0;
            next_s.rx_armed   = 1'b0;
            next_s.rx_nbits   = par_idx + {3'h0, s.fmt.parity_en} + {3'h0, s.fmt.wake_method_select} + 4'h1;
            next_s.rx_sub     = 4'h1;
            next_s.rx_state   = async_m ? serial_mp_pkg::RX_START : serial_mp_pkg::RX_BITS;
          end else begin
            next_s.rx_sub = s.rx_sub + 4'h1;
            if ((!async_m || s.rx_sub == serial_mp_pkg::SUB_LAST) && s.idle_cnt != IDLE_LIMIT) begin
              next_s.idle_cnt = s.idle_cnt + 4'h1;
              if (s.idle_cnt + 4'h1 == IDLE_LIMIT) begin
                next_s.idle_seen = 1'b1;
              end
            end
          end
        end
        serial_mp_pkg::RX_START: begin
          next_s.rx_sub = s.rx_sub + 4'h1;
          if (rxd) begin
            next_s.rx_state = serial_mp_pkg::RX_IDLE;
            next_s.rx_sub   = 4'h0;
          end else if (s.rx_sub == serial_mp_pkg::START_LOW_LAST) begin
            next_s.rx_state = serial_mp_pkg::RX_BITS;
            next_s.rx_sub   = serial_mp_pkg::START_SKIP_TO;
          end
        end
        serial_mp_pkg::RX_BITS: begin
          next_s.rx_sub = s.rx_sub + 4'h1;
          if (async_m && s.rx_sub == serial_mp_pkg::SUB_LAST) begin
            next_s.rx_armed = 1'b1;
            next_s.rx_vote  = 2'h0;
          end
          if (async_m && s.rx_armed &&
              (s.rx_sub == serial_mp_pkg::VOTE_FIRST || s.rx_sub == serial_mp_pkg::VOTE_SECOND)) begin
            next_s.rx_vote = s.rx_vote + {1'b0, rxd};
          end
          if (!async_m || (s.rx_armed && s.rx_sub == serial_mp_pkg::VOTE_DECIDE)) begin
            next_s.rx_armed = 1'b0;
            next_s.rx_shifter[s.rx_idx] = async_m ? vote_bit : rxd;
            next_s.rx_idx = s.rx_idx + 4'h1;
            if (s.rx_idx + 4'h1 == s.rx_nbits) begin
              next_s.rx_state = (async_m ? vote_bit : rxd) ? serial_mp_pkg::RX_IDLE : serial_mp_pkg::RX_BREAK;
              next_s.brk_cnt  = 4'h0;
              // dormant receiver drops data frames without a trace
              if ((!s.receive_dormant || frame_addr) && s.rx_enable) begin
                next_s.rx_holding_buffer = rx_data;
                next_s.rx_full_flag      = 1'b1;
                next_s.err_overrun       = next_s.err_overrun || s.rx_full_flag;
                next_s.rx_address_flag   = frame_addr;
                next_s.err_parity        = next_s.err_parity || rx_par_bad;
                next_s.err_framing       = next_s.err_framing || !(async_m ? vote_bit : rxd);
              end
            end
          end
        end
        serial_mp_pkg::RX_BREAK: begin
          next_s.rx_sub = s.rx_sub + 4'h1;
          if (rxd) begin
            next_s.rx_state = serial_mp_pkg::RX_IDLE;
          end else if ((!async_m || s.rx_sub == serial_mp_pkg::SUB_LAST) && s.brk_cnt != serial_mp_pkg::BREAK_BITS) begin
            next_s.brk_cnt = s.brk_cnt + 4'h1;
            if (s.brk_cnt + 4'h1 == serial_mp_pkg::BREAK_BITS && !s.receive_dormant) begin
              next_s.break_seen_flag = 1'b1;
            end
          end
        end
      endcase
    end

    // ==========================================================================
    // transmitter
    if (tx_edge) begin
      if (s.tx_state == serial_mp_pkg::TX_SHIFT && s.tx_left != 4'h0) begin
        next_s.serial_out = s.tx_shifter[0];
        next_s.tx_shifter = {1'b1, s.tx_shifter[12:1]};
        next_s.tx_left    = s.tx_left - 4'h1;
      end else if (s.tx_enable && !s.tx_empty_flag) begin
        next_s.tx_state      = serial_mp_pkg::TX_SHIFT;
        next_s.serial_out    = tx_frame.bits[0];
        next_s.tx_shifter    = {1'b1, tx_frame.bits[12:1]};
        next_s.tx_left       = tx_frame.nbits - 4'h1;
        next_s.tx_mark_latch = s.tx_block_mark;
        next_s.tx_block_mark = 1'b0;
        next_s.tx_empty_flag = 1'b1;
      end else begin
        next_s.tx_state   = serial_mp_pkg::TX_IDLE;
        next_s.serial_out = 1'b1;
      end
    end

    // ==========================================================================
    // register writes after the load, so a write in the load cycle survives
    if (access && apb_req.pwrite) begin
      unique case (apb_req.paddr)
        serial_mp_pkg::OFS_FRAME: next_s.fmt = apb_req.pwdata[7:0];
        serial_mp_pkg::OFS_BAUD:  next_s.baud = apb_req.pwdata[15:0];
        serial_mp_pkg::OFS_LINE: begin
          next_s.rx_enable       = apb_req.pwdata[serial_mp_pkg::LINE_RX_EN];
          next_s.tx_enable       = apb_req.pwdata[serial_mp_pkg::LINE_TX_EN];
          next_s.receive_dormant = apb_req.pwdata[serial_mp_pkg::LINE_DORMANT];
          next_s.tx_block_mark   = apb_req.pwdata[serial_mp_pkg::LINE_MARK];
          next_s.clk_internal    = apb_req.pwdata[serial_mp_pkg::LINE_INT_CLK];
        end
        serial_mp_pkg::OFS_TXCTL:  next_s.tx_irq_en = apb_req.pwdata[serial_mp_pkg::TXC_IRQ_EN];
        serial_mp_pkg::OFS_RXSTAT: next_s.rx_irq_en = apb_req.pwdata[serial_mp_pkg::RXS_IRQ_EN];
        serial_mp_pkg::OFS_PINCTL: next_s.clock_pin_role = apb_req.pwdata[serial_mp_pkg::PIN_ROLE];
        serial_mp_pkg::OFS_TX_HOLDING_BUFFER: begin
          next_s.tx_holding_buffer = apb_req.pwdata[7:0];
          next_s.tx_empty_flag     = 1'b0;
        end
        default: next_s.rsp = next_s.rsp;
      endcase
    end

    // zero-wait slave: answer prepared in setup, shown in access
    next_s.rsp.pready  = setup;
    next_s.rsp.pslverr = setup && !reg_mapped(apb_req.paddr);
    next_s.rsp.prdata  = (setup && !apb_req.pwrite) ? read_word(s, apb_req.paddr) : 32'h0000_0000;

    next_s.rx_irq = s.rx_irq_en && (s.rx_full_flag || s.break_seen_flag);
    next_s.tx_irq = s.tx_irq_en && s.tx_empty_flag;
  end

  // ==========================================================================
  // registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      s                 <= '0;
      s.rxd_s1          <= 1'b1;
      s.rxd_s2          <= 1'b1;
      s.clk_oe_n        <= 1'b1;
      s.fmt             <= serial_mp_pkg::FRAME_RESET;
      s.baud            <= serial_mp_pkg::BAUD_RESET;
      s.tx_empty_flag   <= 1'b1;
      s.tx_state        <= serial_mp_pkg::TX_IDLE;
      s.tx_shifter      <= '1;
      s.serial_out      <= 1'b1;
      s.rx_state        <= serial_mp_pkg::RX_IDLE;
    end else begin
      s <= next_s;
    end
  end

  assign apb_rsp               = s.rsp;
  assign serial_out_pin        = s.serial_out;
  assign serial_bit_clock_out  = s.sclk;
  assign serial_bit_clock_oe_n = s.clk_oe_n;
  assign rx_irq                = s.rx_irq;
  assign tx_irq                = s.tx_irq;

endmodule : serial_multiproc_wake_modes

// ==== testbench/serial_mp_asserts.sv ====
// checker of bus answers, pin states and interrupt masking of the serial port
`timescale 1ns/1ps
module serial_mp_asserts (
  input wire logic                    mclk,
  input wire logic                    rst,
  input wire serial_mp_pkg::apb_req_t apb_req,
  input wire serial_mp_pkg::apb_rsp_t apb_rsp,
  input wire logic                    serial_out_pin,
  input wire logic                    serial_bit_clock_out,
  input wire logic                    serial_bit_clock_oe_n,
  input wire logic                    rx_irq,
  input wire logic                    tx_irq
);
  // ==========================================================================
  // relations
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  logic setup, done, bad;
  assign setup = apb_req.psel && !apb_req.penable;
  assign done  = apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite && !apb_req.pwdata[0];
  assign bad   = apb_req.paddr > 8'h1C || apb_req.paddr[1:0] != 2'h0;
  a_ready_after_setup: assert property (setup |=> apb_rsp.pready) else $error("no ready after setup");
  a_ready_one_cycle: assert property (apb_rsp.pready |=> !apb_rsp.pready) else $error("ready too long");
  a_bad_addr_error: assert property (setup && bad |=> apb_rsp.pslverr) else $error("no error");
  a_good_addr_ok: assert property (setup && !bad |=> !apb_rsp.pslverr) else $error("false error");
  a_error_reads_zero: assert property (apb_rsp.pslverr |-> apb_rsp.prdata == 32'h0) else $error("error data");
  a_reset_quiet: assert property ($fell(rst) |-> serial_out_pin && serial_bit_clock_oe_n && !rx_irq && !tx_irq)
    else $error("pins not idle after reset");
  a_rx_irq_masked: assert property (done && apb_req.paddr == serial_mp_pkg::OFS_RXSTAT |=> ##1 !rx_irq)
    else $error("rx irq not masked");
  a_tx_irq_masked: assert property (done && apb_req.paddr == serial_mp_pkg::OFS_TXCTL |=> ##1 !tx_irq)
    else $error("tx irq not masked");
  a_clock_runs: assert property (!serial_bit_clock_oe_n |-> ##[1:1000] $changed(serial_bit_clock_out))
    else $error("driven clock stands still");
endmodule : serial_mp_asserts

bind serial_multiproc_wake_modes serial_mp_asserts u_chk (.mclk(mclk), .rst(rst), .apb_req(apb_req),
  .apb_rsp(apb_rsp), .serial_out_pin(serial_out_pin), .serial_bit_clock_out(serial_bit_clock_out),
  .serial_bit_clock_oe_n(serial_bit_clock_oe_n), .rx_irq(rx_irq), .tx_irq(tx_irq));

// ==== testbench/serial_peer.sv ====
// far-end processor sending asynchronous frames onto the shared line
`timescale 1ns/1ps
module serial_peer (
  input  wire logic mclk,
  output logic      line
);
  // ==========================================================================
  // frames, 32 mclk per bit (serial clock at 2 mclk, 16 per bit)
  initial line = 1'b1;
  task automatic send(input logic [7:0] d, input logic ab);
    logic [10:0] f;
    f = {1'b1, ab, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      @(posedge mclk) line <= f[i];
      repeat (31) @(posedge mclk);
    end
  endtask : send
  // low pulse of a few serial clocks only, must not count as a start
  task automatic glitch();
    @(posedge mclk) line <= 1'b0;
    repeat (6) @(posedge mclk);
    line <= 1'b1;
  endtask : glitch
endmodule : serial_peer

// ==== testbench/tb_serial_multiproc_wake_modes.sv ====
// self-checking bench: registers, wake-up filtering, async receive and transmit
`timescale 1ns/1ps
module tb_serial_multiproc_wake_modes;
  logic                    mclk     = 1'b0;
  logic                    rst      = 1'b1;
  logic                    link_clk = 1'b0;
  logic                    link_on  = 1'b0;
  serial_mp_pkg::apb_req_t req      = '0;
  serial_mp_pkg::apb_rsp_t rsp;
  logic                    rx_line, tx_line, er, rxi, txi;
  logic [31:0]             rd;
  logic [7:0]              b;
  logic [10:0]             cap;
  int                      n_errors = 0, cmp_count = 0, cyc = 0, seed = 36821, n;

  always #2.5 mclk = ~mclk;
  // far-side clock only moves while a frame is on the line
  always #40 if (link_on) link_clk = ~link_clk;

  serial_multiproc_wake_modes dut (.mclk(mclk), .rst(rst), .apb_req(req), .apb_rsp(rsp),
    .serial_in_pin(rx_line), .serial_out_pin(tx_line), .serial_bit_clock_in(link_clk),
    .serial_bit_clock_out(), .serial_bit_clock_oe_n(), .rx_irq(rxi), .tx_irq(txi));
  serial_peer u_peer (.mclk(mclk), .line(rx_line));

  // ==========================================================================
  // tasks
  task automatic wrap_up();
    $display("errors %0d comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk) req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge mclk) req.penable <= 1'b1;
    @(posedge mclk);
    while (rsp.pready !== 1'b1) @(posedge mclk);
    rd = rsp.prdata;
    er = rsp.pslverr;
    req <= '0;
  endtask : apb
  task automatic rx_case(input logic ab, input logic full);
    b = 8'($random(seed));
    link_on = 1'b1;
    u_peer.send(b, ab);
    link_on = 1'b0;
    repeat (8) @(posedge mclk);
    apb(1'b0, serial_mp_pkg::OFS_RXSTAT, 32'h0);
    chk(32'(rd[serial_mp_pkg::RXS_FULL]), 32'(full), "rx full");
    if (full) begin
      chk(32'(rxi), 32'(rd[serial_mp_pkg::RXS_IRQ_EN]), "rx irq");
      chk(32'(rd[serial_mp_pkg::RXS_ADDR]), 32'(ab), "address flag");
      apb(1'b0, serial_mp_pkg::OFS_RX_HOLDING_BUFFER, 32'h0);
      chk(rd, {24'h0, b}, "rx data");
      apb(1'b0, serial_mp_pkg::OFS_RXSTAT, 32'h0);
      chk(32'(rd[serial_mp_pkg::RXS_FULL]), 32'h0, "read clears full");
    end
  endtask : rx_case
  task automatic grab(input int nb, input int per);
    for (n = 0; tx_line !== 1'b0 && n < 400; n++) @(posedge mclk);
    repeat (per / 2) @(posedge mclk);
    for (int i = 0; i < nb; i++) begin
      cap[i] = tx_line;
      repeat (per) @(posedge mclk);
    end
  endtask : grab

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_errors++;
      wrap_up();
    end
  end

  // ==========================================================================
  // sequence
  initial begin
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    apb(1'b0, serial_mp_pkg::OFS_FRAME, 32'h0);
    chk(rd, 32'h0, "frame reset");
    apb(1'b0, serial_mp_pkg::OFS_TXCTL, 32'h0);
    chk(32'(rd[7]), 32'h1, "tx empty at reset");
    apb(1'b0, 8'h20, 32'h0);
    chk(32'(er), 32'h1, "unmapped error");
    apb(1'b1, serial_mp_pkg::OFS_PINCTL, 32'h2);
    apb(1'b1, serial_mp_pkg::OFS_FRAME, 32'h1F);
    apb(1'b1, serial_mp_pkg::OFS_RXSTAT, 32'h1);
    apb(1'b1, serial_mp_pkg::OFS_TXCTL, 32'h1);
    apb(1'b1, serial_mp_pkg::OFS_LINE, 32'h17);
    rx_case(1'b0, 1'b0);
    rx_case(1'b1, 1'b1);
    apb(1'b0, serial_mp_pkg::OFS_LINE, 32'h0);
    chk(32'(rd[serial_mp_pkg::LINE_DORMANT]), 32'h1, "dormant kept");
    apb(1'b1, serial_mp_pkg::OFS_LINE, 32'h13);
    u_peer.glitch();
    repeat (400) @(posedge mclk);
    apb(1'b0, serial_mp_pkg::OFS_RXSTAT, 32'h0);
    chk(32'(rd[serial_mp_pkg::RXS_FULL]), 32'h0, "glitch ignored");
    rx_case(1'b0, 1'b1);
    apb(1'b1, serial_mp_pkg::OFS_LINE, 32'h12);
    rx_case(1'b0, 1'b0);
    apb(1'b1, serial_mp_pkg::OFS_RXSTAT, 32'h0);
    apb(1'b1, serial_mp_pkg::OFS_LINE, 32'h1B);
    for (int k = 0; k < 2; k++) begin
      b = 8'($random(seed));
      apb(1'b1, serial_mp_pkg::OFS_TX_HOLDING_BUFFER, {24'h0, b});
      grab(11, 32);
      chk(32'(cap), 32'({1'b1, k == 0, b, 1'b0}), "tx frame");
      apb(1'b0, serial_mp_pkg::OFS_LINE, 32'h0);
      chk(32'(rd[serial_mp_pkg::LINE_MARK]), 32'h0, "mark cleared");
    end
    apb(1'b0, serial_mp_pkg::OFS_TXCTL, 32'h0);
    chk(32'(rd[7]), 32'h1, "tx buffer free");
    chk(32'(txi), 32'h1, "tx irq");
    apb(1'b1, serial_mp_pkg::OFS_FRAME, 32'h17);
    apb(1'b1, serial_mp_pkg::OFS_LINE, 32'h1F);
    rx_case(1'b1, 1'b1);
    rx_case(1'b1, 1'b0);
    apb(1'b1, serial_mp_pkg::OFS_TX_HOLDING_BUFFER, $random(seed));
    while (!rd[7]) apb(1'b0, serial_mp_pkg::OFS_TXCTL, 32'h0);
    b = 8'($random(seed));
    apb(1'b1, serial_mp_pkg::OFS_TX_HOLDING_BUFFER, {24'h0, b});
    grab(10, 32);
    // poll and write eat a few cycles of the idle stretch
    chk(32'((n + 16) / 32), 32'd11, "block start idle");
    chk(32'(cap[9:0]), 32'({1'b1, b, 1'b0}), "address after idle");
    apb(1'b1, serial_mp_pkg::OFS_FRAME, 32'h07);
    apb(1'b1, serial_mp_pkg::OFS_TX_HOLDING_BUFFER, {24'h0, b});
    grab(10, 2);
    chk(32'(cap[9:0]), 32'({1'b1, b, 1'b0}), "isosync frame");
    apb(1'b1, serial_mp_pkg::OFS_TXCTL, 32'h0);
    repeat (4) @(posedge mclk);
    wrap_up();
  end
endmodule : tb_serial_multiproc_wake_modes
